//--- hw/timer_flags_top.sv
// Contract
// - A capture or compare event on a channel sets that channel's event flag.
// - Writing one to a channel flag bit clears it; writing zero leaves it.
// - With fast clear, reading a capture value or writing a compare value clears its flag.
// - Writing one to the overflow flag clears it.
// - With fast clear, any access to the counter register clears the overflow flag.
// - Overflow flag, bit 7, sets when the 16-bit count wraps from maximum to zero.
// - Value registers always readable; writes ignored while the channel captures.
// - Direction selects capture (latch count on edge) or compare (value drives action).
// - Registers decode relative to base 0x0200 blocking and 0x300 non-blocking.
// - Four 16-bit value registers, consecutive byte pairs, reset to zero. The code puts each in its own word, 8 bytes apart.
// - Channel interrupt requested only while its flag and enable are both set.
// - Overflow interrupt requested only while overflow flag and its enable are set.
// - Without fast clear, only write-one clears flags; other accesses leave them.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module timer_flags_top
  import timer_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          hsel,
  input  wire logic [timer_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output var  logic                          hreadyout,
  output var  logic [31:0]                   hrdata,
  output var  logic                          hresp,
  input  wire logic [timer_pkg::CNT_W-1:0]   free_running_count,
  input  wire logic [timer_pkg::NUM_CH-1:0]  capture_strobe,
  input  wire logic [timer_pkg::NUM_CH-1:0]  compare_match,
  output var  logic [timer_pkg::NUM_CH-1:0][timer_pkg::CNT_W-1:0] channel_value,
  output var  logic [timer_pkg::NUM_CH-1:0]  channel_direction_select,
  output var  logic [timer_pkg::NUM_CH-1:0]  channel_irq,
  output var  logic                          overflow_irq,
  output var  logic                          irq
);

  import timer_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              dp_write;
    logic              dp_read;
    logic              dp_hit;
    logic [7:0]        dp_index;
    logic [3:0]        dp_lanes;
    logic [7:0]        control;
    logic [7:0]        irq_enable;
    logic [CNT_W-1:0]  prev_count;
    logic [31:0]       rdata;
    logic              ready;
    logic [NUM_CH-1:0] channel_irq;
    logic              overflow_irq;
    logic              irq;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic [NUM_CH-1:0]             channel_event_flag;
  logic                          counter_overflow_flag;
  logic [NUM_CH-1:0]             ch_set;
  logic [NUM_CH-1:0]             ch_clear;
  logic                          ovf_set;
  logic                          ovf_clear;
  logic [NUM_CH-1:0]             write_hi;
  logic [NUM_CH-1:0]             write_lo;
  logic [NUM_CH-1:0]             read_hi;
  logic [NUM_CH-1:0][CNT_W-1:0]  value;
  logic [NUM_CH-1:0][7:0]        low_buffer;
  logic                          take;
  logic                          addr_hit;
  logic [7:0]                    addr_index;
  logic [8:0]                    addr_decode;
  logic [3:0]                    addr_lanes;
  logic                          wr_now;
  logic                          rd_now;
  logic                          fast_clear_enable;
  logic [NUM_CH-1:0]             dir;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] idx);
    logic hit;
    hit = (idx == IDX_EVENT_FLAGS) || (idx == IDX_OVF_FLAG) || (idx == IDX_CONTROL) ||
          (idx == IDX_COUNT) || (idx == IDX_IRQ_ENABLE);
    for (int n = 0; n < NUM_CH; n++)
      hit = hit || (idx == IDX_VALUE[n]);
    return hit;
  endfunction

  // The two windows overlap; the blocking window is tried first, so the
  // non-blocking copy of the map is reached only above the blocking one.
  function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - BASE_BLOCKING;
    if (a < BASE_BLOCKING || off[ADDR_W-1:WIN_W] != '0)
      off = a - BASE_NONBLOCKING;
    if (a < BASE_BLOCKING || off[ADDR_W-1:WIN_W] != '0)
      return {1'b0, 8'h00};
    return {is_mapped(off[WIN_W-1:2]), off[WIN_W-1:2]};
  endfunction

  function automatic logic [3:0] lanes_of(input logic [2:0] size, input logic [1:0] lo);
    if (size == HSIZE_BYTE)
      return 4'b0001 << lo;
    if (size == HSIZE_HALF)
      return lo[1] ? 4'b1100 : 4'b0011;
    return 4'b1111;
  endfunction

  assign take       = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
  assign addr_decode = decode(haddr);
  assign addr_hit   = addr_decode[8];
  assign addr_index = addr_decode[7:0];
  assign addr_lanes = lanes_of(hsize, haddr[1:0]);

  assign wr_now            = state_reg.dp_write && state_reg.dp_hit;
  assign rd_now            = state_reg.dp_read && state_reg.dp_hit;
  assign fast_clear_enable = state_reg.control[FAST_CLEAR_BIT];
  assign dir               = state_reg.control[CH_FIELD_LSB +: NUM_CH];

  // ---------------------------------------------------------------------------
  // Flag set and clear terms
  // ---------------------------------------------------------------------------
  always_comb
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      ch_set[n]   = dir[n] ? compare_match[n] : capture_strobe[n];
      ch_clear[n] = wr_now && state_reg.dp_index == IDX_EVENT_FLAGS && state_reg.dp_lanes[0] &&
                    hwdata[CH_FIELD_LSB + n];
      // Fast clear only acts when enabled; otherwise value accesses touch no flag.
      if (fast_clear_enable && state_reg.dp_index == IDX_VALUE[n])
        ch_clear[n] = ch_clear[n] || (dir[n] ? wr_now : rd_now);
      write_hi[n] = wr_now && state_reg.dp_index == IDX_VALUE[n] && state_reg.dp_lanes[1];
      write_lo[n] = wr_now && state_reg.dp_index == IDX_VALUE[n] && state_reg.dp_lanes[0];
      read_hi[n]  = rd_now && state_reg.dp_index == IDX_VALUE[n] &&
                    state_reg.dp_lanes[1] && !state_reg.dp_lanes[0];
    end
  end

  assign ovf_set   = state_reg.prev_count == COUNT_MAX && free_running_count == COUNT_ZERO;
  assign ovf_clear = (wr_now && state_reg.dp_index == IDX_OVF_FLAG && state_reg.dp_lanes[0] &&
                      hwdata[OVF_BIT]) ||
                     (fast_clear_enable && (wr_now || rd_now) &&
                      state_reg.dp_index == IDX_COUNT);

  // ---------------------------------------------------------------------------
  // Flags and channel value registers
  // ---------------------------------------------------------------------------
  sticky_flags #(
    .WIDTH (NUM_CH)
  ) u_channel_flags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set     (ch_set),
    .clear   (ch_clear),
    .flags   (channel_event_flag)
  );

  sticky_flags #(
    .WIDTH (1)
  ) u_overflow_flag (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set     (ovf_set),
    .clear   (ovf_clear),
    .flags   (counter_overflow_flag)
  );

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chan
    chan_value_reg u_value (
      .ref_clk            (ref_clk),
      .reset              (reset),
      .output_compare     (dir[g]),
      .capture_strobe     (capture_strobe[g]),
      .free_running_count (free_running_count),
      .write_hi           (write_hi[g]),
      .write_lo           (write_lo[g]),
      .write_data         (hwdata[CNT_W-1:0]),
      .read_hi            (read_hi[g]),
      .value              (value[g]),
      .low_buffer         (low_buffer[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Bus sequencing, registers and interrupt requests
  // ---------------------------------------------------------------------------
  // Reads take one wait state so that read data are sampled after any write
  // that finished in the same cycle the read was addressed.
  always_comb
  begin
    state_next            = state_reg;
    state_next.prev_count = free_running_count;

    if (wr_now && state_reg.dp_index == IDX_CONTROL && state_reg.dp_lanes[0])
      state_next.control = hwdata[7:0] & CONTROL_MASK;
    if (wr_now && state_reg.dp_index == IDX_IRQ_ENABLE && state_reg.dp_lanes[0])
      state_next.irq_enable = hwdata[7:0] & IRQ_ENABLE_MASK;

    if (state_reg.dp_read)
    begin
      state_next.rdata = 32'h0000_0000;
      if (state_reg.dp_hit)
      begin
        case (state_reg.dp_index)
          IDX_EVENT_FLAGS: state_next.rdata[CH_FIELD_LSB +: NUM_CH] = channel_event_flag;
          IDX_OVF_FLAG:    state_next.rdata[OVF_BIT] = counter_overflow_flag;
          IDX_CONTROL:     state_next.rdata[7:0] = state_reg.control;
          IDX_COUNT:       state_next.rdata[CNT_W-1:0] = free_running_count;
          IDX_IRQ_ENABLE:  state_next.rdata[7:0] = state_reg.irq_enable;
          default:
          begin
            for (int n = 0; n < NUM_CH; n++)
            begin
              if (state_reg.dp_index == IDX_VALUE[n])
              begin
                if (state_reg.dp_lanes == 4'b0001)
                  state_next.rdata[7:0] = low_buffer[n];
                else
                  state_next.rdata[CNT_W-1:0] = value[n];
              end
            end
          end
        endcase
      end
      state_next.dp_read = 1'b0;
      state_next.ready   = 1'b1;
    end

    if (state_reg.dp_write)
      state_next.dp_write = 1'b0;

    if (take)
    begin
      state_next.dp_hit   = addr_hit;
      state_next.dp_index = addr_index;
      state_next.dp_lanes = addr_lanes;
      state_next.dp_write = hwrite;
      state_next.dp_read  = !hwrite;
      state_next.ready    = hwrite;
    end

    state_next.channel_irq  = channel_event_flag & state_reg.irq_enable[CH_FIELD_LSB +: NUM_CH];
    state_next.overflow_irq = counter_overflow_flag && state_reg.irq_enable[OVF_IRQ_EN_BIT];
    state_next.irq          = |state_next.channel_irq || state_next.overflow_irq;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg            <= '0;
      state_reg.control    <= RST_CONTROL;
      state_reg.irq_enable <= RST_IRQ_ENABLE;
      state_reg.ready      <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hreadyout                = state_reg.ready;
  assign hrdata                   = state_reg.rdata;
  assign hresp                    = HRESP_OKAY;
  assign channel_value            = value;
  assign channel_direction_select = dir;
  assign channel_irq              = state_reg.channel_irq;
  assign overflow_irq             = state_reg.overflow_irq;
  assign irq                      = state_reg.irq;

endmodule

`default_nettype wire

//--- hw/timer_pkg.sv
`default_nettype none

package timer_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_CH  = 4;
  localparam int CNT_W   = 16;
  localparam int ADDR_W  = 16;
  localparam int WIN_W   = 10;

  // ---------------------------------------------------------------------------
  // Address windows and register indices (byte address = base + 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] BASE_BLOCKING    = 16'h0200;
  localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;

  localparam logic [NUM_CH-1:0][7:0] IDX_VALUE = {8'hD4, 8'hD2, 8'hD0, 8'hCE};
  localparam logic [7:0] IDX_EVENT_FLAGS  = 8'hE0;
  localparam logic [7:0] IDX_OVF_FLAG     = 8'hE1;
  localparam logic [7:0] IDX_CONTROL      = 8'hE2;
  localparam logic [7:0] IDX_COUNT        = 8'hE3;
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'hE4;

  // ---------------------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------------------
  localparam int OVF_BIT         = 7;
  localparam int FAST_CLEAR_BIT  = 7;
  localparam int OVF_IRQ_EN_BIT  = 7;
  localparam int CH_FIELD_LSB    = 0;
  localparam logic [7:0]  CONTROL_MASK    = 8'h8F;
  localparam logic [7:0]  IRQ_ENABLE_MASK = 8'h8F;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_IRQ_ENABLE  = 8'h00;
  localparam logic [15:0] RST_VALUE       = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;

  // ---------------------------------------------------------------------------
  // AHB-Lite encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_BYTE    = 3'b000;
  localparam logic [2:0] HSIZE_HALF    = 3'b001;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

`default_nettype wire

//--- hw/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int WIDTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clear,
  output var  logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } flag_state_t;

  flag_state_t state_reg;
  flag_state_t state_next;

  // An event landing in the same cycle as its clear keeps the flag set.
  always_comb
  begin
    state_next       = state_reg;
    state_next.flags = (state_reg.flags & ~clear) | set;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign flags = state_reg.flags;

endmodule

`default_nettype wire

//--- hw/chan_value_reg.sv
`timescale 1ns/1ps
`default_nettype none

module chan_value_reg
  import timer_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              output_compare,
  input  wire logic              capture_strobe,
  input  wire logic [CNT_W-1:0]  free_running_count,
  input  wire logic              write_hi,
  input  wire logic              write_lo,
  input  wire logic [CNT_W-1:0]  write_data,
  input  wire logic              read_hi,
  output var  logic [CNT_W-1:0]  value,
  output var  logic [7:0]        low_buffer
);

  typedef struct packed {
    logic [CNT_W-1:0] value;
    logic [7:0]       high_buffer;
    logic [7:0]       low_buffer;
  } chan_state_t;

  chan_state_t state_reg;
  chan_state_t state_next;

  // A lone high-byte write is parked until the low byte arrives, and a lone
  // high-byte read freezes the low byte, so a pair of byte accesses sees one
  // coherent 16-bit value only when the high byte goes first.
  always_comb
  begin
    state_next = state_reg;
    if (read_hi)
      state_next.low_buffer = state_reg.value[7:0];
    if (output_compare)
    begin
      if (write_hi && write_lo)
        state_next.value = write_data;
      else if (write_hi)
        state_next.high_buffer = write_data[15:8];
      else if (write_lo)
        state_next.value = {state_reg.high_buffer, write_data[7:0]};
    end
    else if (capture_strobe)
      state_next.value = free_running_count;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg.value       <= RST_VALUE;
      state_reg.high_buffer <= '0;
      state_reg.low_buffer  <= '0;
    end
    else
      state_reg <= state_next;
  end

  assign value      = state_reg.value;
  assign low_buffer = state_reg.low_buffer;

endmodule

`default_nettype wire

//--- hw/placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- sim/count_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module count_source_model
  import timer_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        load,
  input  wire logic [timer_pkg::CNT_W-1:0] load_value,
  input  wire logic                        run,
  output var  logic [timer_pkg::CNT_W-1:0] free_running_count
);
  // Stands in for the prescaled counter; the bench steps it by hand so that wraps land where it wants them.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      free_running_count <= COUNT_ZERO;
    else if (load)
      free_running_count <= load_value;
    else if (run)
      free_running_count <= free_running_count + 16'h0001;
  end
endmodule

`default_nettype wire

//--- sim/timer_flags_props.sv
`timescale 1ns/1ps
`default_nettype none

module timer_flags_props
  import timer_pkg::*;
(
  input wire logic                                               ref_clk,
  input wire logic                                               reset,
  input wire logic                                               hsel,
  input wire logic [1:0]                                         htrans,
  input wire logic                                               hwrite,
  input wire logic                                               hready,
  input wire logic                                               hreadyout,
  input wire logic [timer_pkg::CNT_W-1:0]                        free_running_count,
  input wire logic [timer_pkg::NUM_CH-1:0]                       capture_strobe,
  input wire logic [timer_pkg::NUM_CH-1:0]                       compare_match,
  input wire logic [timer_pkg::NUM_CH-1:0][timer_pkg::CNT_W-1:0] channel_value,
  input wire logic [timer_pkg::NUM_CH-1:0]                       channel_direction_select,
  input wire logic [timer_pkg::NUM_CH-1:0]                       channel_irq,
  input wire logic                                               overflow_irq,
  input wire logic                                               irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------------------
  // Bus timing
  // ---------------------------------------------------------------------------
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong.");
  a_write_ready: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("Write stalled.");

  // ---------------------------------------------------------------------------
  // Capture and requests
  // ---------------------------------------------------------------------------
  a_cap_latch: assert property (capture_strobe[0] && !channel_direction_select[0] |=>
    channel_value[0] == $past(free_running_count)) else $error("Capture did not latch the count.");
  a_irq_or: assert property (irq == ((|channel_irq) | overflow_irq))
    else $error("Combined request wrong.");
  // Flags only drop through a bus access, so a quiet bus must keep the channel 0 and overflow requests up.
  a_ch_hold: assert property ((!hsel) [*4] ##0 channel_irq[0] |=> channel_irq[0])
    else $error("Channel request dropped without access.");
  a_ovf_hold: assert property ((!hsel) [*4] ##0 overflow_irq |=> overflow_irq)
    else $error("Overflow request dropped without access.");
  a_ch_cause: assert property ($rose(channel_irq[0]) |->
    $past(capture_strobe[0] || compare_match[0], 2) || $past(hsel, 3)) else $error("Channel request without cause.");
  a_ovf_cause: assert property ($rose(overflow_irq) |->
    $past(free_running_count, 2) == COUNT_ZERO || $past(hsel, 3)) else $error("Overflow request without wrap.");
endmodule

bind timer_flags_top timer_flags_props u_props (
  .ref_clk, .reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .free_running_count, .capture_strobe,
  .compare_match, .channel_value, .channel_direction_select, .channel_irq, .overflow_irq, .irq
);

`default_nettype wire

//--- sim/tb_timer_flags_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_timer_flags_top;
  import timer_pkg::*;

  localparam logic [15:0] FLG = BASE_BLOCKING + {6'h00, IDX_EVENT_FLAGS, 2'h0};
  localparam logic [15:0] OVF = BASE_BLOCKING + {6'h00, IDX_OVF_FLAG, 2'h0};
  localparam logic [15:0] CTL = BASE_BLOCKING + {6'h00, IDX_CONTROL, 2'h0};
  localparam logic [15:0] CNT = BASE_BLOCKING + {6'h00, IDX_COUNT, 2'h0};
  localparam logic [15:0] IEN = BASE_BLOCKING + {6'h00, IDX_IRQ_ENABLE, 2'h0};

  logic                         ref_clk = 1'b0;
  logic                         reset = 1'b1;
  logic                         hsel = 1'b0;
  logic                         hwrite = 1'b0;
  logic                         load = 1'b0;
  logic                         run = 1'b0;
  logic [15:0]                  haddr = 16'h0000;
  logic [15:0]                  load_value = 16'h0000;
  logic [1:0]                   htrans = 2'h0;
  logic [2:0]                   hsize = 3'h2;
  logic [31:0]                  hwdata = 32'h0000_0000;
  logic [3:0]                   cap = 4'h0;
  logic [3:0]                   cmp = 4'h0;
  logic                         hready;
  logic                         hreadyout;
  logic                         hresp;
  logic                         overflow_irq;
  logic                         irq;
  logic [31:0]                  hrdata;
  logic [31:0]                  q;
  logic [15:0]                  count;
  logic [3:0]                   dir;
  logic [3:0]                   channel_irq;
  logic [NUM_CH-1:0][CNT_W-1:0] channel_value;
  int                           n_errors = 0;
  int                           n_compared = 0;

  assign hready = hreadyout;

  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  timer_flags_top dut (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .free_running_count(count), .capture_strobe(cap), .compare_match(cmp), .channel_value(channel_value),
    .channel_direction_select(dir), .channel_irq(channel_irq), .overflow_irq(overflow_irq), .irq(irq)
  );

  count_source_model u_count (
    .ref_clk(ref_clk), .reset(reset), .load(load), .load_value(load_value), .run(run),
    .free_running_count(count)
  );

  function automatic logic [15:0] va(input int c, input logic nb);
    return (nb ? BASE_NONBLOCKING : BASE_BLOCKING) + {6'h00, IDX_VALUE[c], 2'h0};
  endfunction

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A stuck slave must not hang the run, so every handshake wait is bounded.
  task automatic wait_rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (hready !== 1'b1 && i < 40);
    if (hready !== 1'b1)
    begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [2:0] sz, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= sz;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, 3'h2, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 3'h2, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic pulse(input logic [3:0] c, input logic [3:0] m);
    @(posedge ref_clk);
    cap <= c;
    cmp <= m;
    @(posedge ref_clk);
    cap <= 4'h0;
    cmp <= 4'h0;
  endtask

  task automatic setc(input logic [15:0] v, input logic r);
    @(posedge ref_clk);
    load       <= 1'b1;
    load_value <= v;
    run        <= r;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      rd(va(c, 1'b0), 32'h0000_0000);
    end
    rd(FLG, 32'h0000_0000);
    rd(16'h0400, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("reset test done");
    setc(16'h1234, 1'b0);
    pulse(4'hF, 4'h0);
    wr(va(1, 1'b0), 32'h0000_AAAA);
    rd(va(1, 1'b0), 32'h0000_1234);
    chk({16'h0000, channel_value[3]}, 32'h0000_1234);
    wr(IEN, 32'h0000_000F);
    repeat (6) @(posedge ref_clk);
    chk({28'h000_0000, channel_irq}, 32'h0000_000F);
    rd(FLG, 32'h0000_000F);
    wr(FLG, 32'h0000_0000);
    rd(FLG, 32'h0000_000F);
    wr(FLG, 32'h0000_000A);
    rd(FLG, 32'h0000_0005);
    wr(IEN, 32'h0000_0001);
    rd(va(0, 1'b0), 32'h0000_1234);
    rd(FLG, 32'h0000_0005);
    chk({28'h000_0000, channel_irq}, 32'h0000_0001);
    wr(CTL, 32'h0000_0080);
    rd(va(0, 1'b1), 32'h0000_1234);
    rd(FLG, 32'h0000_0004);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("capture test done");
    wr(CTL, 32'h0000_008F);
    wr(va(0, 1'b0), 32'h0000_BEEF);
    chk({28'h000_0000, dir}, 32'h0000_000F);
    rd(va(0, 1'b0), 32'h0000_BEEF);
    bus(1'b1, va(3, 1'b0) + 16'h0001, HSIZE_BYTE, 32'h0000_5600);
    bus(1'b1, va(3, 1'b0), HSIZE_BYTE, 32'h0000_0078);
    rd(va(3, 1'b0), 32'h0000_5678);
    bus(1'b0, va(3, 1'b0) + 16'h0001, HSIZE_BYTE, 32'h0000_0000);
    chk(q, 32'h0000_5678);
    wr(va(3, 1'b0), 32'h0000_9999);
    bus(1'b0, va(3, 1'b0), HSIZE_BYTE, 32'h0000_0000);
    chk(q, 32'h0000_0078);
    pulse(4'h0, 4'h1);
    rd(FLG, 32'h0000_0005);
    wr(va(0, 1'b0), 32'h0000_1111);
    rd(FLG, 32'h0000_0004);
    chk({16'h0000, channel_value[0]}, 32'h0000_1111);
    wr(CTL, 32'h0000_000F);
    pulse(4'h0, 4'h1);
    wr(va(0, 1'b0), 32'h0000_2222);
    rd(FLG, 32'h0000_0005);
    // The match pulse is timed to land on the very edge that applies the clear.
    fork
      wr(FLG, 32'h0000_0001);
      begin
        @(posedge ref_clk);
        pulse(4'h0, 4'h1);
      end
    join
    rd(FLG, 32'h0000_0005);
    repeat (6) @(posedge ref_clk);
    $display("compare test done");
    setc(16'hFFFF, 1'b1);
    setc(16'h0100, 1'b0);
    rd(OVF, 32'h0000_0080);
    wr(IEN, 32'h0000_0080);
    repeat (6) @(posedge ref_clk);
    chk({30'h0000_0000, overflow_irq, irq}, 32'h0000_0003);
    rd(CNT, 32'h0000_0100);
    rd(OVF, 32'h0000_0080);
    wr(OVF, 32'h0000_0000);
    rd(OVF, 32'h0000_0080);
    wr(OVF, 32'h0000_0080);
    rd(OVF, 32'h0000_0000);
    chk({31'h0000_0000, overflow_irq}, 32'h0000_0000);
    wr(CTL, 32'h0000_0080);
    setc(16'hFFFF, 1'b1);
    setc(16'h0100, 1'b0);
    rd(CNT, 32'h0000_0100);
    rd(OVF, 32'h0000_0000);
    setc(16'hFFFF, 1'b1);
    setc(16'h0100, 1'b0);
    rd(OVF, 32'h0000_0080);
    wr(CNT, 32'h0000_0000);
    rd(OVF, 32'h0000_0000);
    $display("overflow test done");
    end_sim();
  end
endmodule

`default_nettype wire
